// file: rtl/oss_map.vh
// register offsets, field positions, reset values and codes for the
// oscillator select and status block; included by rtl/oss_osc_select.v
`ifndef OSS_MAP_VH
`define OSS_MAP_VH

// =====================================================================
// register byte addresses (word aligned)
`define OSS_CTRL_ADDR        4'h0
`define OSS_STAT_ADDR        4'h4
`define OSS_UNMAPPED_DATA    32'h0000_0000

// =====================================================================
// control register fields
`define OSS_IFS_HI           6
`define OSS_IFS_LO           3
`define OSS_SCS_HI           1
`define OSS_SCS_LO           0
`define OSS_IFS_RESET        4'h7
`define OSS_SCS_RESET        2'h0

// =====================================================================
// status register field positions
`define OSS_ST_SEC_READY     7
`define OSS_ST_EXT_ACTIVE    5
`define OSS_ST_HF_READY      4
`define OSS_ST_LF_READY      1
`define OSS_ST_HF_STABLE     0

// =====================================================================
// system clock source codes
`define OSS_SCS_CONFIG       2'h0
`define OSS_SCS_SECONDARY    2'h1

// =====================================================================
// source kinds driven on the source select output
`define OSS_SRC_LF           3'h0
`define OSS_SRC_HF           3'h1
`define OSS_SRC_SECONDARY    3'h2
`define OSS_SRC_EXTERNAL     3'h3
`define OSS_SRC_CFG_INT      3'h4

// =====================================================================
// divider codes for the internal block (log2 of 16 MHz divisor)
`define OSS_DIV_16M          4'h0
`define OSS_DIV_8M           4'h1
`define OSS_DIV_4M           4'h2
`define OSS_DIV_2M           4'h3
`define OSS_DIV_1M           4'h4
`define OSS_DIV_500K         4'h5
`define OSS_DIV_250K         4'h6
`define OSS_DIV_125K         4'h7
`define OSS_DIV_62K5         4'h8
`define OSS_DIV_31K25        4'h9
`define OSS_DIV_LF           4'hf

// =====================================================================
// config word clock choice meaning internal oscillator
`define OSS_CFG_INTERNAL     2'h0

`endif

// file: rtl/oss_osc_select.v
// oscillator control and status registers with a glitch-free clock
// switch sequencer; Avalon-MM slave with waitrequest on clk.
// assumes oscillator ready levels arrive asynchronously and that the
// switch handshake comes from the clock gating cell in another domain.
// assumes the gate drops both handshake levels after each switch, the
// config clock choice is a static strap, and the master holds each
// request until it sees waitrequest low.
//
// control register, offset 0x0:
//   bit 7 zero, 6..3 internal frequency select, bit 2 zero,
//   1..0 system clock source select
// status register, offset 0x4:
//   bit 7 secondary ready, 5 external clock active, 4 hf ready,
//   1 lf ready, 0 hf stable, all others zero
// source select out: 0 lf, 1 hf, 2 secondary, 3 external,
//   4 internal named by the config clock choice
// divider select out: log2 of the 16 MHz divisor, f for the lf source
//
// Function
// - control bits 6..3 select the internal frequency per code table.
// - any reset loads the frequency select with 0111 for 500 kHz.
// - codes 1000..1010 give 125/250/500 kHz divided from the hf source.
// - clock select 1x routes the internal block, 01 the secondary osc.
// - clock select 00 takes the source named by the config clock choice.
// - control bits 7 and 2, status bits 6, 3, 2 read zero, drop writes.
// - status bit 7 reports the secondary oscillator ready condition.
// - status bit 5 reports running from the config external source.
// - a switch waits for the old clock low, holds low, new clock rises.
`timescale 1ns/1ps
`include "oss_map.vh"

module oss_osc_select #(
  parameter ADDR_W = 4
) (
  // clock, reset and register bus
  input  wire              clk,
  input  wire              reset,
  input  wire [ADDR_W-1:0] address,
  input  wire              read,
  input  wire              write,
  input  wire [3:0]        byteenable,
  input  wire [31:0]       writedata,
  output reg  [31:0]       readdata,
  output reg               waitrequest,
  // strap and oscillator levels, all asynchronous
  input  wire [1:0]        configClockChoice,
  input  wire              secondaryOscEnable,
  input  wire              secondaryOscRun,
  input  wire              hfInternalReady,
  input  wire              hfInternalStable,
  input  wire              lfInternalReady,
  // clock gate handshake
  input  wire              oldClockLow,
  input  wire              newClockHigh,
  // to the clock gate
  output reg  [2:0]        srcSelect,
  output reg  [3:0]        divSelect,
  output reg               clockHoldLow,
  output reg               switchBusy
);

  // ===================================================================
  // switch sequencer states
  // idle: outputs match the decode, or the gate is not yet released
  // wfall: waiting to see the old clock low
  // wrise: system clock held low, waiting to see the new clock high
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WFALL = 2'h1;
  localparam [1:0] ST_WRISE = 2'h2;

  // ===================================================================
  // input synchronisers: first stage feeds only the second
  // levels only; a pulse shorter than one clock may be lost
  localparam NSYNC = 7;
  wire [NSYNC-1:0] asyncIn;
  reg  [NSYNC-1:0] syncA_r;
  reg  [NSYNC-1:0] syncB_r;
  assign asyncIn = {secondaryOscEnable, secondaryOscRun, hfInternalReady,
                    hfInternalStable, lfInternalReady, oldClockLow,
                    newClockHigh};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : gSync
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          syncA_r[gi] <= 1'b0;
          syncB_r[gi] <= 1'b0;
        end else begin
          syncA_r[gi] <= asyncIn[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate

  wire secEnS    = syncB_r[6];
  wire secRunS   = syncB_r[5];
  wire hfRdyS    = syncB_r[4];
  wire hfStabS   = syncB_r[3];
  wire lfRdyS    = syncB_r[2];
  wire oldLowS   = syncB_r[1];
  wire newHighS  = syncB_r[0];

  // config word strap: two flops like every other pin
  // a strap change still goes through the switch sequencer
  reg [1:0] cfgMeta_r;
  reg [1:0] cfgChoice_r;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfgMeta_r   <= `OSS_CFG_INTERNAL;
      cfgChoice_r <= `OSS_CFG_INTERNAL;
    end else begin
      cfgMeta_r   <= configClockChoice;
      cfgChoice_r <= cfgMeta_r;
    end
  end

  // ===================================================================
  // bus decode
  wire       ctrlHit = (address == `OSS_CTRL_ADDR);
  wire       statHit = (address == `OSS_STAT_ADDR);
  // single-cycle wait so every access sees one wait state
  wire       accept  = (read | write) & waitrequest;
  // the edge at which the master sees waitrequest low ends the access;
  // a write lands there and nowhere else
  wire       commit  = (read | write) & ~waitrequest;

  // ===================================================================
  // control register
  reg  [3:0] intFreqSelect_r;
  reg  [1:0] sysClockSourceSelect_r;

  // written only at the completing edge of a lane 0 control write
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      intFreqSelect_r        <= `OSS_IFS_RESET;
      sysClockSourceSelect_r <= `OSS_SCS_RESET;
    end else if (commit && write && ctrlHit && byteenable[0]) begin
      // bits 7 and 2 are not stored at all
      intFreqSelect_r        <= writedata[`OSS_IFS_HI:`OSS_IFS_LO];
      sysClockSourceSelect_r <= writedata[`OSS_SCS_HI:`OSS_SCS_LO];
    end
  end

  // ===================================================================
  // frequency decode: divider code and which internal source
  // codes 8..a reuse the hf divider taps, so moving between a code
  // and its duplicate needs no switch at all
  reg [3:0] divNxt;
  reg       useHfNxt;
  always @* begin
    useHfNxt = 1'b1;
    divNxt   = `OSS_DIV_16M;
    case (intFreqSelect_r)
      4'h0, 4'h1: begin
        divNxt   = `OSS_DIV_LF;
        useHfNxt = 1'b0;
      end
      4'h2, 4'h3: divNxt = `OSS_DIV_31K25;
      4'h4: divNxt = `OSS_DIV_62K5;
      4'h5: divNxt = `OSS_DIV_125K;
      4'h6: divNxt = `OSS_DIV_250K;
      4'h7: divNxt = `OSS_DIV_500K;
      // duplicates taken straight from the hf source divider
      4'h8: divNxt = `OSS_DIV_125K;
      4'h9: divNxt = `OSS_DIV_250K;
      4'ha: divNxt = `OSS_DIV_500K;
      4'hb: divNxt = `OSS_DIV_1M;
      4'hc: divNxt = `OSS_DIV_2M;
      4'hd: divNxt = `OSS_DIV_4M;
      4'he: divNxt = `OSS_DIV_8M;
      default: divNxt = `OSS_DIV_16M;
    endcase
  end

  // ===================================================================
  // source selection
  reg [2:0] srcNxt;
  always @* begin
    if (sysClockSourceSelect_r[1])
      srcNxt = useHfNxt ? `OSS_SRC_HF : `OSS_SRC_LF;
    else if (sysClockSourceSelect_r == `OSS_SCS_SECONDARY)
      srcNxt = `OSS_SRC_SECONDARY;
    else if (cfgChoice_r == `OSS_CFG_INTERNAL)
      srcNxt = `OSS_SRC_CFG_INT;
    else
      srcNxt = `OSS_SRC_EXTERNAL;
  end

  // ===================================================================
  // switch sequencer: old clock low, hold, then new clock high
  reg [1:0] state_r;
  reg [2:0] pendSrc_r;
  reg [3:0] pendDiv_r;
  wire      changeReq = (srcNxt != srcSelect) || (divNxt != divSelect);
  // gate levels lag two flops; a new switch waits until both are seen
  // low again, or a stale high would skip the falling-edge wait
  wire      gateIdle  = ~oldLowS & ~newHighS;
  wire      startSw   = changeReq & gateIdle;

  // pending codes latched at the start; later writes wait their turn
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r      <= ST_IDLE;
      srcSelect    <= `OSS_SRC_HF;
      divSelect    <= `OSS_DIV_500K;
      pendSrc_r    <= `OSS_SRC_HF;
      pendDiv_r    <= `OSS_DIV_500K;
      clockHoldLow <= 1'b0;
      switchBusy   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (startSw) begin
            pendSrc_r  <= srcNxt;
            pendDiv_r  <= divNxt;
            switchBusy <= 1'b1;
            state_r    <= ST_WFALL;
          end
        end
        ST_WFALL: begin
          if (oldLowS) begin
            clockHoldLow <= 1'b1;
            state_r      <= ST_WRISE;
          end
        end
        ST_WRISE: begin
          if (newHighS) begin
            srcSelect    <= pendSrc_r;
            divSelect    <= pendDiv_r;
            clockHoldLow <= 1'b0;
            switchBusy   <= 1'b0;
            state_r      <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ===================================================================
  // status bits: hardware driven only, never written
  // ready copies lag their pins by the two synchroniser flops
  wire secReady  = secEnS ? secRunS : 1'b1;
  wire extActive = (srcSelect == `OSS_SRC_EXTERNAL);
  reg [7:0] statusVal;
  always @* begin
    statusVal = 8'h00;
    statusVal[`OSS_ST_SEC_READY]  = secReady;
    statusVal[`OSS_ST_EXT_ACTIVE] = extActive;
    statusVal[`OSS_ST_HF_READY]   = hfRdyS;
    statusVal[`OSS_ST_LF_READY]   = lfRdyS;
    statusVal[`OSS_ST_HF_STABLE]  = hfStabS;
  end

  // ===================================================================
  // read data mux; unmapped offsets read as zero
  reg [31:0] readNxt;
  always @* begin
    readNxt = `OSS_UNMAPPED_DATA;
    if (ctrlHit)
      readNxt = {24'h0, 1'b0, intFreqSelect_r, 1'b0,
                 sysClockSourceSelect_r};
    else if (statHit)
      readNxt = {24'h0, statusVal};
  end

  // ===================================================================
  // bus answer: waitrequest drops one cycle after the request
  // fixed one wait state; readdata then stands until the next read
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= `OSS_UNMAPPED_DATA;
    end else begin
      waitrequest <= ~accept;
      if (accept && read)
        readdata <= readNxt;
    end
  end

endmodule

// file: dv/oss_osc_select_chk.sv
// assertions on the oscillator select block ports
// assumes oss_map.vh on the include path
`timescale 1ns/1ps
`include "oss_map.vh"
module oss_osc_select_chk #(
  parameter ADDR_W = 4
) (
  input wire              clk,
  input wire              reset,
  input wire [ADDR_W-1:0] address,
  input wire              read,
  input wire              write,
  input wire [31:0]       readdata,
  input wire              waitrequest,
  input wire              secondaryOscEnable,
  input wire              lfInternalReady,
  input wire              oldClockLow,
  input wire              clockHoldLow,
  input wire              switchBusy,
  input wire [2:0]        srcSelect,
  input wire [3:0]        divSelect
);
  // ==========================================================
  // reads completing in this cycle
  wire rdOk = read && !waitrequest;
  wire stRd = rdOk && address == `OSS_STAT_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ans;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_s0;
    stRd |-> (readdata & 32'hffffff4c) == 32'h0;
  endproperty
  a_s0: assert property (p_s0) else $error("status pad bit");
  property p_um;
    rdOk && address != `OSS_CTRL_ADDR && !stRd |-> readdata == 32'h0;
  endproperty
  a_um: assert property (p_um) else $error("unmapped data");
  // sync lag is two cycles, so six stable cycles settle the copy
  property p_sec;
    !secondaryOscEnable [*6] ##0 stRd |-> readdata[7];
  endproperty
  a_sec: assert property (p_sec) else $error("ready bit low");
  property p_lf;
    $stable(lfInternalReady) [*6] ##0 stRd |-> readdata[1] == lfInternalReady;
  endproperty
  a_lf: assert property (p_lf) else $error("lf ready copy");
  property p_hold;
    $rose(clockHoldLow) |-> switchBusy && $past(oldClockLow, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("early hold");
  property p_chg;
    $changed(srcSelect) || $changed(divSelect) |-> $past(clockHoldLow);
  endproperty
  a_chg: assert property (p_chg) else $error("unheld switch");
endmodule
bind oss_osc_select oss_osc_select_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// file: dv/oss_osc_select_tb.sv
// self-checking bench for the oscillator select block
// assumes design and checker compiled before it
`timescale 1ns/1ps
module oss_osc_select_tb;
  reg         clk = 0, reset = 1, read = 0, write = 0;
  reg  [3:0]  address = 4'h0, byteenable = 4'hf, a;
  reg  [31:0] writedata = 32'h0, seed = 32'h6bf3, d, w;
  reg  [1:0]  cfg = 2'h0;
  reg         secEn = 0, secRun = 0, hfR = 0, hfS = 0, lfR = 0;
  reg         oldLow = 0, newHigh = 0;
  reg  [7:0]  ctl;
  wire [31:0] readdata;
  wire [2:0]  srcSelect;
  wire [3:0]  divSelect;
  wire        waitrequest, clockHoldLow, switchBusy;
  integer     fail_count = 0, n_compared = 0, i, r;
  always #12.5 clk = ~clk;
  oss_osc_select i_dut (.clk(clk), .reset(reset), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .configClockChoice(cfg), .secondaryOscEnable(secEn),
    .secondaryOscRun(secRun), .hfInternalReady(hfR),
    .hfInternalStable(hfS), .lfInternalReady(lfR), .oldClockLow(oldLow),
    .newClockHigh(newHigh), .srcSelect(srcSelect), .divSelect(divSelect),
    .clockHoldLow(clockHoldLow), .switchBusy(switchBusy));
  // ==========================================================
  // helpers
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  task finish_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus access; waits out waitrequest under a bound
  task bus(input wr, input [3:0] ad, input [31:0] v);
    integer k;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= ad;
    writedata <= v;
    k = 0;
    do begin
      @(posedge clk);
      k = k + 1;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      chk(0, 1);
      finish_test;
    end
    d = readdata;
    read <= 0;
    write <= 0;
  endtask
  // plays the clock gate; the old clock goes low only after busy
  task sw;
    integer k;
    for (k = 0; k < 12 && !switchBusy; k = k + 1) @(posedge clk);
    if (switchBusy) begin
      repeat (4) @(posedge clk);
      chk(clockHoldLow, 0);
      oldLow <= 1;
      for (k = 0; k < 20 && !clockHoldLow; k = k + 1) @(posedge clk);
      chk(clockHoldLow, 1);
      if (clockHoldLow !== 1'b1) finish_test;
      newHigh <= 1;
      for (k = 0; k < 20 && switchBusy; k = k + 1) @(posedge clk);
      chk({switchBusy, clockHoldLow}, 0);
      if (switchBusy !== 1'b0) finish_test;
      oldLow <= 0;
      newHigh <= 0;
    end
  endtask
  // ==========================================================
  // main sequence: two resets, every code on the first pass and even codes on the second, then random traffic
  initial begin
    for (r = 0; r < 2; r = r + 1) begin
      reset <= 1;
      repeat (20) @(posedge clk);
      reset <= 0;
      ctl = 8'h38;
      bus(0, 4'h0, 0);
      chk(d, 32'h38);
      sw;
      for (i = 0; i < 40; i = r + i + 1) begin
        d = rnd();
        cfg <= d[9:8];
        {secEn, secRun, hfR, hfS, lfR} <= d[14:10];
        byteenable <= {d[23:21], i < 16 || d[24]};
        w = i < 16 ? {d[7], i[3:0], d[2], 1'b1, d[0]} : d[7:0];
        a = i < 16 ? 4'h0 : {d[26:25], 2'h0};
        bus(1, a, w);
        if (a == 4'h0 && byteenable[0]) ctl = w[7:0] & 8'h7b;
        sw;
        sw;
        bus(0, 4'h0, 0);
        chk(d, ctl);
        chk(divSelect, ctl[6:4] == 0 ? 4'hf :
          ctl[6:4] == 1 ? 4'h9 : ctl[6] ? 4'hf - ctl[6:3] :
          4'hc - ctl[6:3]);
        chk(srcSelect, ctl[1] ? (ctl[6:4] == 0 ? 3'h0 : 3'h1) :
          ctl[0] ? 3'h2 : (cfg == 0 ? 3'h4 : 3'h3));
        bus(0, 4'h4, 0);
        chk(d, {secEn ? secRun : 1'b1, 1'b0, ctl[1:0] == 0 && cfg != 0,
          hfR, 2'h0, lfR, hfS});
        bus(0, 4'h8, 0);
        chk(d, 0);
      end
    end
    finish_test;
  end
endmodule
